// >>> src/qsr_top.v
// Queue manager status reporting: transmit space and receive header status
//
// Function
// [R01] Free transmit space reads as a 13-bit byte count, bits 15-13 zero.
// [R02] The free count accounts for both frame payload and control word.
// [R03] The host checks the free count covers a whole frame before writing.
// [R04] The location between the two status registers reads zero, no effect.
// [R05] Frame valid is set when the head frame is complete with valid status.
// [R06] Frame valid is clear with no pending frame or one still arriving.
// [R07] ICMP checksum bit is set for a received bad ICMP checksum.
// [R08] IP checksum bit is set for a received bad IP header checksum.
// [R09] TCP checksum bit is set for a received bad TCP checksum.
// [R10] UDP checksum bit is set for a received bad UDP checksum.
// [R11] Broadcast flag is set for a broadcast destination.
// [R12] Multicast flag is set for multicast and also broadcast destinations.
// [R13] Unicast flag is set for a unicast destination.
// [R14] One status word per counted frame, read once by the host per frame.
// [R15] Interface error bit is set when a symbol error hit the frame.
//
// Local design decision: the APB interface to the registers.
`include "qsr_regs.vh"

module qsr_top #(
  parameter TX_DEPTH  = `QSR_TX_DEPTH,
  parameter RXQ_DEPTH = `QSR_RXQ_DEPTH,
  parameter RXQ_AW    = 3
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        SYS_RST,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Transmit queue accounting
  input  wire        TX_ALLOC_VALID,
  input  wire [12:0] TX_ALLOC_BYTES,
  input  wire        TX_RELEASE_VALID,
  input  wire [12:0] TX_RELEASE_BYTES,
  // Received frame completion
  input  wire        RX_FRAME_DONE,
  input  wire [47:0] RX_DEST_ADDR,
  input  wire        RX_ICMP_SUM_BAD,
  input  wire        RX_IP_SUM_BAD,
  input  wire        RX_TCP_SUM_BAD,
  input  wire        RX_UDP_SUM_BAD,
  input  wire        RX_INTERFACE_SYMBOL_ERROR,
  // Interrupt
  output reg         IRQ
);

  // ========================================================================
  // Destination address class
  // First byte on the wire sits in bits 47:40; its low bit is the group bit
  function [2:0] addr_class;
    input [47:0] da;
    reg          bc;
    reg          mc;
    begin
      bc = (da == 48'hFFFF_FFFF_FFFF);
      mc = da[40];
      addr_class = {bc, mc, !mc};
    end
  endfunction

  // ========================================================================
  // Signals
  wire [12:0]       tx_space_bytes;
  wire [15:0]       rx_head_word;
  wire [RXQ_AW:0]   rx_frame_counter;
  wire              rx_overflow;
  wire [2:0]        rx_class;
  wire [8:0]        rx_flags;
  wire              rx_is_broadcast;
  wire              rx_is_multicast;
  wire              rx_is_unicast;
  wire              acc;
  wire              done;
  wire              rd_done;
  wire              wr_done;
  wire              hit_txspace;
  wire              hit_rsvd;
  wire              hit_rxstat;
  wire              hit_stat;
  wire              hit_mask;
  wire              hit_cnt;
  wire              mapped;
  wire              rx_pop;
  wire              sum_bad;
  reg  [31:0]       rdata_d;
  reg  [`QSR_INT_W-1:0] int_stat_q;
  reg  [`QSR_INT_W-1:0] int_stat_d;
  reg  [`QSR_INT_W-1:0] int_mask_q;
  reg  [`QSR_INT_W-1:0] int_mask_d;
  reg  [`QSR_INT_W-1:0] events;

  // ========================================================================
  // Transmit space
  qsr_tx_space #(
    .DEPTH         (TX_DEPTH)
  ) u_tx_space (
    .clk           (CLOCK),
    .rst           (SYS_RST),
    .alloc_valid   (TX_ALLOC_VALID),
    .alloc_bytes   (TX_ALLOC_BYTES),
    .release_valid (TX_RELEASE_VALID),
    .release_bytes (TX_RELEASE_BYTES),
    .free_bytes    (tx_space_bytes)
  );

  // ========================================================================
  // Receive status capture
  assign rx_class        = addr_class(RX_DEST_ADDR);
  assign rx_is_broadcast = rx_class[2]; // [R11]
  assign rx_is_multicast = rx_class[1]; // [R12]
  assign rx_is_unicast   = rx_class[0]; // [R13]

  // Packed order: icmp ip tcp udp bcast mcast ucast symerr, pad bit 0
  assign rx_flags = {RX_ICMP_SUM_BAD,            // [R07]
                     RX_IP_SUM_BAD,              // [R08]
                     RX_TCP_SUM_BAD,             // [R09]
                     RX_UDP_SUM_BAD,             // [R10]
                     rx_is_broadcast,
                     rx_is_multicast,
                     rx_is_unicast,
                     RX_INTERFACE_SYMBOL_ERROR,  // [R15]
                     1'b0};

  qsr_rx_status #(
    .DEPTH     (RXQ_DEPTH),
    .AW        (RXQ_AW)
  ) u_rx_status (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .push      (RX_FRAME_DONE),
    .flags_in  (rx_flags),
    .pop       (rx_pop),
    .head_word (rx_head_word),
    .count     (rx_frame_counter),
    .overflow  (rx_overflow)
  );

  // ========================================================================
  // APB decode
  // One wait state: PREADY rises in the second access cycle
  assign acc     = PSEL && PENABLE;
  assign done    = acc && PREADY;
  assign rd_done = done && !PWRITE;
  assign wr_done = done && PWRITE;

  assign hit_txspace = (PADDR == `QSR_TXSPACE_ADDR);
  assign hit_rsvd    = (PADDR == `QSR_RSVD_ADDR);
  assign hit_rxstat  = (PADDR == `QSR_RXSTAT_ADDR);
  assign hit_stat    = (PADDR == `QSR_INT_STAT_ADDR);
  assign hit_mask    = (PADDR == `QSR_INT_MASK_ADDR);
  assign hit_cnt     = (PADDR == `QSR_FRMCNT_ADDR);
  assign mapped      = hit_txspace || hit_rsvd || hit_rxstat ||
                       hit_stat || hit_mask || hit_cnt;

  // Reading the status word hands the host the next frame's word;
  // only a word shown as valid is consumed, so a frame that lands
  // between capture and completion is not lost
  assign rx_pop = rd_done && hit_rxstat && PRDATA[`QSR_RXS_VALID]; // [R14]

  always @*
  begin
    rdata_d = `QSR_ZERO32;
    if (hit_txspace)
      rdata_d = {19'h0_0000, tx_space_bytes}; // [R01]
    else if (hit_rsvd)
      rdata_d = `QSR_ZERO32; // [R04]
    else if (hit_rxstat)
      rdata_d = {16'h0000, rx_head_word}; // [R05] [R06]
    else if (hit_stat)
      rdata_d = {27'h000_0000, int_stat_q};
    else if (hit_mask)
      rdata_d = {27'h000_0000, int_mask_q};
    else if (hit_cnt)
      rdata_d = {{(31-RXQ_AW){1'b0}}, rx_frame_counter}; // [R14]
  end

  always @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= `QSR_ZERO32;
      PSLVERR <= 1'b0;
    end
    else if (acc && !PREADY)
    begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? `QSR_ZERO32 : rdata_d;
      // Writes to read-only status locations are ignored, not errors
      PSLVERR <= !mapped;
    end
    else
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // ========================================================================
  // Interrupt status and mask
  assign sum_bad = RX_ICMP_SUM_BAD || RX_IP_SUM_BAD ||
                   RX_TCP_SUM_BAD || RX_UDP_SUM_BAD;

  always @*
  begin
    events = {`QSR_INT_W{1'b0}};
    events[`QSR_INT_RX_FRAME] = RX_FRAME_DONE && !rx_overflow;
    events[`QSR_INT_RX_SUM]   = RX_FRAME_DONE && sum_bad;
    events[`QSR_INT_RX_SYM]   = RX_FRAME_DONE && RX_INTERFACE_SYMBOL_ERROR;
    events[`QSR_INT_RX_OVF]   = rx_overflow;
    events[`QSR_INT_TX_FREED] = TX_RELEASE_VALID;
    int_stat_d = int_stat_q;
    // Clear only the bits the host was shown; later events survive
    if (rd_done && hit_stat)
      int_stat_d = int_stat_d & ~PRDATA[`QSR_INT_W-1:0];
    int_stat_d = int_stat_d | events;
    int_mask_d = int_mask_q;
    if (wr_done && hit_mask)
      int_mask_d = PWDATA[`QSR_INT_W-1:0];
  end

  always @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      int_stat_q <= {`QSR_INT_W{1'b0}};
      int_mask_q <= `QSR_INT_MASK_RST;
      IRQ        <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      IRQ        <= |(int_stat_d & int_mask_d);
    end
  end

endmodule // qsr_top

// >>> src/qsr_regs.vh
// Register map, field positions and reset values of the queue status block
`ifndef QSR_REGS_VH
`define QSR_REGS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define QSR_TXSPACE_IDX        12'h078
`define QSR_RSVD_IDX           12'h07A
`define QSR_RXSTAT_IDX         12'h07C
`define QSR_TXSPACE_ADDR       12'h1E0
`define QSR_RSVD_ADDR          12'h1E8
`define QSR_RXSTAT_ADDR        12'h1F0

// ==========================================================================
// Interrupt and counter registers
`define QSR_INT_STAT_ADDR      12'h200
`define QSR_INT_MASK_ADDR      12'h204
`define QSR_FRMCNT_ADDR        12'h208

// ==========================================================================
// Receive status word field positions
`define QSR_RXS_VALID          15
`define QSR_RXS_ICMP           13
`define QSR_RXS_IP             12
`define QSR_RXS_TCP            11
`define QSR_RXS_UDP            10
`define QSR_RXS_BCAST          7
`define QSR_RXS_MCAST          6
`define QSR_RXS_UCAST          5
`define QSR_RXS_SYMERR         4

// ==========================================================================
// Interrupt status bits
`define QSR_INT_RX_FRAME       0
`define QSR_INT_RX_SUM         1
`define QSR_INT_RX_SYM         2
`define QSR_INT_RX_OVF         3
`define QSR_INT_TX_FREED       4
`define QSR_INT_W              5

// ==========================================================================
// Reset values and sizes
`define QSR_TX_DEPTH           6144
`define QSR_RXQ_DEPTH          8
`define QSR_INT_MASK_RST       5'h00
`define QSR_ZERO32             32'h0000_0000

`endif

// >>> src/qsr_tx_space.v
// Transmit queue free space tracker
`include "qsr_regs.vh"

module qsr_tx_space #(
  parameter DEPTH = `QSR_TX_DEPTH
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Space taken by a frame written: payload plus control word
  input  wire        alloc_valid,
  input  wire [12:0] alloc_bytes,
  // Space given back once a frame has left the queue
  input  wire        release_valid,
  input  wire [12:0] release_bytes,
  // Free space in bytes
  output wire [12:0] free_bytes
);

  localparam [13:0] DEPTH_W = DEPTH[13:0];

  reg  [13:0] used_q;
  reg  [13:0] used_d;
  wire [13:0] take;
  wire [13:0] give;

  // Oversized allocations are dropped so the count never wraps
  assign take = (alloc_valid && ({1'b0, alloc_bytes} <= (DEPTH_W - used_q)))
                ? {1'b0, alloc_bytes} : 14'h0000;
  assign give = (release_valid && ({1'b0, release_bytes} <= used_q))
                ? {1'b0, release_bytes} : used_q & {14{release_valid}};

  always @*
  begin
    used_d = used_q + take - give; // [R02]
  end

  always @(posedge clk)
  begin
    if (rst)
      used_q <= 14'h0000;
    else
      used_q <= used_d;
  end

  assign free_bytes = (DEPTH_W - used_q) > 14'h1FFF ? 13'h1FFF
                      : (DEPTH_W[12:0] - used_q[12:0]); // [R01]

endmodule // qsr_tx_space

// >>> src/qsr_rx_status.v
// Per-frame receive status word queue
`include "qsr_regs.vh"

module qsr_rx_status #(
  parameter DEPTH = `QSR_RXQ_DEPTH,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Completed frame from the receiver
  input  wire        push,
  input  wire [8:0]  flags_in,
  // Host has consumed the head status word
  input  wire        pop,
  // Head word, frame count, overflow pulse
  output wire [15:0] head_word,
  output wire [AW:0] count,
  output wire        overflow
);

  reg  [8:0]  mem [0:DEPTH-1];
  reg  [AW:0] cnt_q;
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  wire        empty;
  wire        full;
  wire        do_push;
  wire        do_pop;
  wire [8:0]  h;

  assign empty   = (cnt_q == {(AW+1){1'b0}});
  assign full    = (cnt_q == DEPTH[AW:0]);
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign overflow = push && !do_push;
  assign h = mem[rd_q];

  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_q] <= flags_in;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= {(AW+1){1'b0}};
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 1'b1;
      if (do_pop)
        rd_q <= rd_q + 1'b1;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + 1'b1; // [R14]
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - 1'b1; // [R14]
    end
  end

  // Valid only once a frame is complete; a frame in flight is never queued
  assign head_word = empty ? 16'h0000 :
    {1'b1, 1'b0, h[8], h[7], h[6], h[5], 2'b00,
     h[4], h[3], h[2], h[1], 4'h0}; // [R05] [R06]
  assign count = cnt_q;

endmodule // qsr_rx_status

// >>> tb/qsr_host_model.sv
// Host processor model issuing APB transfers to the status block
module qsr_host_model (
  // Clock
  input  wire logic        clk,
  // APB request
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h000,
  output logic [31:0]      pwdata  = 32'h0000_0000,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // One transfer; ready and read data are taken at the rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
endmodule // qsr_host_model

// >>> tb/qsr_top_props.sv
// Concurrent checks on the queue status block ports
`include "qsr_regs.vh"
module qsr_top_props (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire rd_ok = PREADY && !PWRITE && !PSLVERR;
  wire rd_st = rd_ok && (PADDR == `QSR_RXSTAT_ADDR);
  // ====
  // Transfer timing
  sequence setup_s;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  a_ready_one_wait: assert property (setup_s |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  // ====
  // Read data contents
  a_txfree_rsvd: assert property (rd_ok && PADDR == `QSR_TXSPACE_ADDR
    |-> PRDATA[31:13] == 19'h0_0000) else $error("free space upper bits set");
  a_gap_zero: assert property (rd_ok && PADDR == `QSR_RSVD_ADDR
    |-> PRDATA == 32'h0000_0000) else $error("reserved location not zero");
  a_rxs_rsvd: assert property (rd_st && PRDATA[15]
    |-> PRDATA[31:16] == 16'h0000 && !PRDATA[14] && PRDATA[9:8] == 2'b00)
    else $error("status word reserved bits set");
  a_empty_zero: assert property (rd_st && !PRDATA[15]
    |-> PRDATA == 32'h0000_0000) else $error("flags without valid frame");
  a_bc_is_mc: assert property (rd_st && PRDATA[7] |-> PRDATA[6])
    else $error("broadcast without multicast");
  a_uc_only: assert property (rd_st && PRDATA[5]
    |-> PRDATA[7:6] == 2'b00) else $error("unicast with group flag");
  a_rxs_one_class: assert property (rd_st && PRDATA[15]
    |-> PRDATA[6] != PRDATA[5]) else $error("address class not unique");
endmodule // qsr_top_props

bind qsr_top qsr_top_props chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// >>> tb/qsr_top_tb_top.sv
// Self-checking bench for the queue status block
`include "qsr_regs.vh"
module qsr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [47:0] da; logic [3:0] sums; logic sym;
                  logic [15:0] word;} qsr_row_t;
  logic        clock = 1'b0, sys_rst = 1'b1, irq;
  logic        tx_av = 1'b0, tx_rv = 1'b0, rx_done = 1'b0, sym = 1'b0;
  logic [12:0] tx_n = 13'h0000;
  logic [47:0] da = 48'h0000_0000_0000;
  logic [3:0]  sums = 4'h0;
  logic [31:0] d;
  logic        e;
  wire  logic  psel, penable, pwrite, pready, pslverr;
  wire  logic [11:0] paddr;
  wire  logic [31:0] pwdata, prdata;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  qsr_row_t    rows [4];
  always #2.5 clock = ~clock;
  qsr_top dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_ALLOC_VALID(tx_av), .TX_ALLOC_BYTES(tx_n), .TX_RELEASE_VALID(tx_rv),
    .TX_RELEASE_BYTES(tx_n), .RX_FRAME_DONE(rx_done), .RX_DEST_ADDR(da),
    .RX_ICMP_SUM_BAD(sums[3]), .RX_IP_SUM_BAD(sums[2]),
    .RX_TCP_SUM_BAD(sums[1]), .RX_UDP_SUM_BAD(sums[0]),
    .RX_INTERFACE_SYMBOL_ERROR(sym), .IRQ(irq));
  qsr_host_model host_u (.clk(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0000_0000, d, e);
    chk($sformatf("read %h", a), d, exp);
  endtask
  task automatic tx(input logic alloc, input logic [12:0] n);
    @(posedge clock);
    tx_av <= alloc;
    tx_rv <= !alloc;
    tx_n  <= n;
    @(posedge clock);
    tx_av <= 1'b0;
    tx_rv <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ====
  // Hang guard, tests need about 115 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  // ====
  // Main sequence
  initial
  begin
    rows[0] = '{48'hFFFF_FFFF_FFFF, 4'h8, 1'b0, 16'hA0C0};
    rows[1] = '{48'h0100_5E00_0001, 4'h4, 1'b0, 16'h9040};
    rows[2] = '{48'h0011_2233_4455, 4'h2, 1'b0, 16'h8820};
    rows[3] = '{48'h0211_2233_4455, 4'h1, 1'b1, 16'h8430};
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`QSR_TXSPACE_ADDR, 32'h0000_1800);
    if (d[12:0] >= 13'h0064) tx(1'b1, 13'h0064);
    rd(`QSR_TXSPACE_ADDR, 32'h0000_179C);
    tx(1'b1, 13'h1B58);
    rd(`QSR_TXSPACE_ADDR, 32'h0000_179C);
    tx(1'b0, 13'h0064);
    rd(`QSR_TXSPACE_ADDR, 32'h0000_1800);
    rd(`QSR_RSVD_ADDR, 32'h0000_0000);
    host_u.xfer(1'b0, 12'h300, 32'h0000_0000, d, e);
    chk("unmapped error", {31'h0, e}, 32'h0000_0001);
    host_u.xfer(1'b1, `QSR_INT_MASK_ADDR, 32'h0000_0001, d, e);
    foreach (rows[i])
    begin
      @(posedge clock);
      rx_done <= 1'b1;
      da      <= rows[i].da;
      sums    <= rows[i].sums;
      sym     <= rows[i].sym;
    end
    @(posedge clock);
    rx_done <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd(`QSR_INT_STAT_ADDR, 32'h0000_0017);
    rd(`QSR_FRMCNT_ADDR, 32'h0000_0004);
    foreach (rows[i])
    begin
      host_u.xfer(1'b0, `QSR_RXSTAT_ADDR, 32'h0000_0000, d, e);
      chk("rx valid", {31'h0, d[15]}, {31'h0, rows[i].word[15]});
      chk("rx icmp", {31'h0, d[13]}, {31'h0, rows[i].word[13]});
      chk("rx ip", {31'h0, d[12]}, {31'h0, rows[i].word[12]});
      chk("rx tcp", {31'h0, d[11]}, {31'h0, rows[i].word[11]});
      chk("rx udp", {31'h0, d[10]}, {31'h0, rows[i].word[10]});
      chk("rx bcast", {31'h0, d[7]}, {31'h0, rows[i].word[7]});
      chk("rx mcast", {31'h0, d[6]}, {31'h0, rows[i].word[6]});
      chk("rx ucast", {31'h0, d[5]}, {31'h0, rows[i].word[5]});
      chk("rx word", d, {16'h0000, rows[i].word});
    end
    rd(`QSR_RXSTAT_ADDR, 32'h0000_0000);
    rd(`QSR_FRMCNT_ADDR, 32'h0000_0000);
    #1 chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    tx(1'b1, 13'h0200);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd(`QSR_TXSPACE_ADDR, 32'h0000_1800);
    // Nine frames back to back: the ninth finds the queue full
    sums    <= 4'h0;
    sym     <= 1'b0;
    da      <= 48'h0011_2233_4455;
    rx_done <= 1'b1;
    repeat (9) @(posedge clock);
    rx_done <= 1'b0;
    rd(`QSR_FRMCNT_ADDR, 32'h0000_0008);
    rd(`QSR_INT_STAT_ADDR, 32'h0000_0009);
    #1 chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    tally_and_finish;
  end
endmodule // qsr_top_tb_top
